// ===== design/rscb_consts.svh
// Offsets, field positions, reset values and masks of the radio state configuration bank
`ifndef RSCB_CONSTS_SVH
`define RSCB_CONSTS_SVH

`define RSCB_ADDR_W 6
`define RSCB_ADDR_FREQ_DEV 6'h15
`define RSCB_ADDR_RX_TMO 6'h16
`define RSCB_ADDR_NEXT_ST 6'h17

`define RSCB_RST_FREQ_DEV 8'h47
`define RSCB_RST_RX_TMO 8'h07
`define RSCB_RST_NEXT_ST 8'h30

`define RSCB_MASK_FREQ_DEV 8'h77
`define RSCB_MASK_RX_TMO 8'h1f
`define RSCB_MASK_NEXT_ST 8'h3f

`define RSCB_DEV_E_MSB 6
`define RSCB_DEV_E_LSB 4
`define RSCB_DEV_M_MSB 2
`define RSCB_DEV_M_LSB 0

`define RSCB_TMO_CS_BIT 4
`define RSCB_TMO_QUAL_BIT 3
`define RSCB_TMO_SEL_MSB 2
`define RSCB_TMO_SEL_LSB 0
`define RSCB_TMO_NONE 3'h7

`define RSCB_NS_CCA_MSB 5
`define RSCB_NS_CCA_LSB 4
`define RSCB_NS_RX_MSB 3
`define RSCB_NS_RX_LSB 2
`define RSCB_NS_TX_MSB 1
`define RSCB_NS_TX_LSB 0

`define RSCB_CNT_W 17
`define RSCB_DEV_W 11

`endif

// ===== design/rscb_pkg.sv
// Types of the radio state configuration bank
package rscb_pkg;

  typedef enum logic [1:0] {
    RSCB_ST_IDLE,
    RSCB_ST_SYNTH_ON_FOR_TX,
    RSCB_ST_TX,
    RSCB_ST_RX
  } rscb_radio_state_t;

  typedef enum logic [1:0] {
    RSCB_CC_ALWAYS,
    RSCB_CC_RSSI,
    RSCB_CC_NOT_RX,
    RSCB_CC_BOTH
  } rscb_clear_channel_sel_t;

  typedef enum logic [0:0] {
    RSCB_TMR_IDLE,
    RSCB_TMR_RUN
  } rscb_tmr_state_t;

endpackage

// ===== design/rscb_tmr_if.sv
// Carrier between the bank and its receive timeout counter
`timescale 1ns/1ps
`include "rscb_consts.svh"
interface rscb_tmr_if;
  logic start;
  logic abort;
  logic rc_tick;
  logic [`RSCB_CNT_W-1:0] period;
  logic expired;
  logic running;

  modport bank (output start, output abort, output rc_tick, output period,
                input expired, input running);
  modport timer (input start, input abort, input rc_tick, input period,
                 output expired, output running);
endinterface

// ===== design/rscb_rx_timer.sv
// Receive sync-search timeout counter clocked by the core clock, counting RC oscillator ticks
`timescale 1ns/1ps
`include "rscb_consts.svh"
module rscb_rx_timer
  import rscb_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  rscb_tmr_if.timer tif
);

  rscb_tmr_state_t state_q;
  logic [`RSCB_CNT_W-1:0] cnt_q;
  logic expired_q;

  assign tif.expired = expired_q;
  assign tif.running = (state_q == RSCB_TMR_RUN);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= RSCB_TMR_IDLE;
      cnt_q <= '0;
      expired_q <= 1'b0;
    end else begin
      expired_q <= 1'b0;
      unique case (state_q)
        RSCB_TMR_IDLE: begin
          if (tif.start) begin
            // A zero period still waits one RC tick
            cnt_q <= (tif.period == '0) ? `RSCB_CNT_W'(1) : tif.period;
            state_q <= RSCB_TMR_RUN;
          end
        end
        RSCB_TMR_RUN: begin
          if (tif.abort) begin
            state_q <= RSCB_TMR_IDLE;
          end else if (tif.rc_tick) begin
            if (cnt_q == `RSCB_CNT_W'(1)) begin
              expired_q <= 1'b1;
              state_q <= RSCB_TMR_IDLE;
            end else begin
              cnt_q <= cnt_q - `RSCB_CNT_W'(1);
            end
          end
        end
      endcase
    end
  end

endmodule

// ===== design/rscb_top.sv
// Radio state configuration bank: deviation, receive timeout and next-state control
//
// Behaviour
// - FSK deviation is fxosc/2^17 times (8+mantissa) times 2^exponent.
// - Mantissa bits 2:0 carry implicit leading one; reset value seven.
// - In MSK mode the mantissa sets phase-change fraction of a symbol.
// - Carrier-sense termination bit ends receive on carrier-sense measurement; checked only at timer expiry, ending receive without carrier sense.
// - On timer expiry stay in receive on sync, or sync/preamble quality.
// - Timeout field limits sync search; setting seven means no timeout.
// - Timeout scales with wake period, halving with each setting step.
// - Count uses 13 wake period MSBs at setting 0, 7 at 6.
// - Clear-channel mode selects always, RSSI, not-receiving, or both; reset 3.
// - After reception go idle, synth-on, transmit or stay receiving; reset 0.
// - After transmission go idle, synth-on, stay transmitting or receive; reset 0.
`timescale 1ns/1ps
`include "rscb_consts.svh"
module rscb_top
  import rscb_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [`RSCB_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic msk_mode_i,
  input wire logic [15:0] wake_event_period_i,
  input wire logic [1:0] wake_timer_resolution_i,
  input wire logic rc_osc_clk_i,
  input wire logic rx_active_i,
  input wire logic sync_found_i,
  input wire logic pqt_reached_i,
  input wire logic carrier_sense_i,
  input wire logic rssi_below_thr_i,
  input wire logic pkt_receiving_i,
  input wire logic rx_done_i,
  input wire logic tx_done_i,
  output logic [`RSCB_DEV_W-1:0] fsk_dev_steps_o,
  output logic [2:0] msk_phase_frac_o,
  output logic rx_end_o,
  output logic rx_timer_running_o,
  output logic cca_o,
  output rscb_radio_state_t next_state_o,
  output logic next_state_valid_o
);

  logic [7:0] freq_deviation_cfg_q;
  logic [7:0] radio_fsm_rx_timeout_cfg_q;
  logic [7:0] radio_fsm_next_state_cfg_q;
  logic [2:0] rc_sync_q;
  logic rx_active_q;
  logic [3:0] dev_mant4;
  logic [2:0] dev_exp;
  logic [2:0] rx_time_sel;
  logic [12:0] tmo_base;
  logic [`RSCB_CNT_W-1:0] tmo_scale;
  logic rx_stay;
  rscb_clear_channel_sel_t clear_channel_sel;

  rscb_tmr_if tif ();

  rscb_rx_timer u_rx_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tif(tif)
  );

  // Register writes; reserved positions are masked off
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      freq_deviation_cfg_q <= `RSCB_RST_FREQ_DEV;
      radio_fsm_rx_timeout_cfg_q <= `RSCB_RST_RX_TMO;
      radio_fsm_next_state_cfg_q <= `RSCB_RST_NEXT_ST;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `RSCB_ADDR_FREQ_DEV: begin
          freq_deviation_cfg_q <= reg_wdata_i & `RSCB_MASK_FREQ_DEV;
        end
        `RSCB_ADDR_RX_TMO: begin
          radio_fsm_rx_timeout_cfg_q <= reg_wdata_i & `RSCB_MASK_RX_TMO;
        end
        `RSCB_ADDR_NEXT_ST: begin
          radio_fsm_next_state_cfg_q <= reg_wdata_i & `RSCB_MASK_NEXT_ST;
        end
        default: begin
        end
      endcase
    end
  end

  // Read data follows the address one cycle later; unmapped reads zero
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      unique case (reg_addr_i)
        `RSCB_ADDR_FREQ_DEV: begin
          reg_rdata_o <= freq_deviation_cfg_q;
        end
        `RSCB_ADDR_RX_TMO: begin
          reg_rdata_o <= radio_fsm_rx_timeout_cfg_q;
        end
        `RSCB_ADDR_NEXT_ST: begin
          reg_rdata_o <= radio_fsm_next_state_cfg_q;
        end
        default: begin
          reg_rdata_o <= 8'h00;
        end
      endcase
    end
  end

  // Deviation: MSK reuses the mantissa, so FSK steps are zeroed there
  assign dev_exp = freq_deviation_cfg_q[`RSCB_DEV_E_MSB:`RSCB_DEV_E_LSB];
  assign dev_mant4 = {1'b1, freq_deviation_cfg_q[`RSCB_DEV_M_MSB:`RSCB_DEV_M_LSB]};

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fsk_dev_steps_o <= '0;
      msk_phase_frac_o <= 3'h0;
    end else if (msk_mode_i) begin
      fsk_dev_steps_o <= '0;
      msk_phase_frac_o <= freq_deviation_cfg_q[`RSCB_DEV_M_MSB:`RSCB_DEV_M_LSB];
    end else begin
      fsk_dev_steps_o <= `RSCB_DEV_W'({7'h00, dev_mant4} << dev_exp);
      msk_phase_frac_o <= 3'h0;
    end
  end

  // RC oscillator arrives from its own domain; third flop only feeds edge detection
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rc_sync_q <= 3'h0;
    end else begin
      rc_sync_q <= {rc_sync_q[1:0], rc_osc_clk_i};
    end
  end

  assign rx_time_sel = radio_fsm_rx_timeout_cfg_q[`RSCB_TMO_SEL_MSB:`RSCB_TMO_SEL_LSB];
  // Coarse count: resolution lost in the dropped low bits is a known limitation
  assign tmo_base = wake_event_period_i[15:3] >> rx_time_sel;
  assign tmo_scale = `RSCB_CNT_W'({wake_timer_resolution_i, 2'b00}) + `RSCB_CNT_W'(1);

  assign tif.rc_tick = rc_sync_q[1] & ~rc_sync_q[2];
  assign tif.period = `RSCB_CNT_W'(`RSCB_CNT_W'(tmo_base) * tmo_scale);
  assign tif.start = rx_active_i & ~rx_active_q & (rx_time_sel != `RSCB_TMO_NONE);
  assign tif.abort = ~rx_active_i;

  always_comb begin
    if (radio_fsm_rx_timeout_cfg_q[`RSCB_TMO_CS_BIT]) begin
      rx_stay = carrier_sense_i;
    end else if (radio_fsm_rx_timeout_cfg_q[`RSCB_TMO_QUAL_BIT]) begin
      rx_stay = sync_found_i | pqt_reached_i;
    end else begin
      rx_stay = sync_found_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rx_active_q <= 1'b0;
      rx_end_o <= 1'b0;
      rx_timer_running_o <= 1'b0;
    end else begin
      rx_active_q <= rx_active_i;
      rx_end_o <= tif.expired & rx_active_i & ~rx_stay;
      rx_timer_running_o <= tif.running;
    end
  end

  // Clear-channel indication
  assign clear_channel_sel = rscb_clear_channel_sel_t'(
    radio_fsm_next_state_cfg_q[`RSCB_NS_CCA_MSB:`RSCB_NS_CCA_LSB]);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cca_o <= 1'b0;
    end else begin
      unique case (clear_channel_sel)
        RSCB_CC_ALWAYS: begin
          cca_o <= 1'b1;
        end
        RSCB_CC_RSSI: begin
          cca_o <= rssi_below_thr_i;
        end
        RSCB_CC_NOT_RX: begin
          cca_o <= ~pkt_receiving_i;
        end
        RSCB_CC_BOTH: begin
          cca_o <= rssi_below_thr_i & ~pkt_receiving_i;
        end
      endcase
    end
  end

  // Both next-state fields share the same state order
  function automatic rscb_radio_state_t rscb_decode_state(input logic [1:0] code);
    rscb_radio_state_t st;
    unique case (code)
      2'h0: st = RSCB_ST_IDLE;
      2'h1: st = RSCB_ST_SYNTH_ON_FOR_TX;
      2'h2: st = RSCB_ST_TX;
      2'h3: st = RSCB_ST_RX;
    endcase
    return st;
  endfunction

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      next_state_o <= RSCB_ST_IDLE;
      next_state_valid_o <= 1'b0;
    end else begin
      next_state_valid_o <= rx_done_i | tx_done_i;
      if (rx_done_i) begin
        next_state_o <= rscb_decode_state(
          radio_fsm_next_state_cfg_q[`RSCB_NS_RX_MSB:`RSCB_NS_RX_LSB]);
      end else if (tx_done_i) begin
        next_state_o <= rscb_decode_state(
          radio_fsm_next_state_cfg_q[`RSCB_NS_TX_MSB:`RSCB_NS_TX_LSB]);
      end
    end
  end

endmodule

// ===== verification/rscb_assertions.sv
// Assertion checker bound to the radio state configuration bank
`timescale 1ns/1ps
`include "rscb_consts.svh"
module rscb_assertions
  import rscb_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [`RSCB_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic msk_mode_i,
  input wire logic rx_active_i,
  input wire logic rx_timer_running_o,
  input wire logic sync_found_i,
  input wire logic rssi_below_thr_i,
  input wire logic pkt_receiving_i,
  input wire logic rx_done_i,
  input wire logic tx_done_i,
  input wire logic [`RSCB_DEV_W-1:0] fsk_dev_steps_o,
  input wire logic [2:0] msk_phase_frac_o,
  input wire logic rx_end_o,
  input wire logic cca_o,
  input rscb_radio_state_t next_state_o,
  input wire logic next_state_valid_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Shadows follow the writes, so nothing is read back from the design
  logic [7:0] dev_q, tmo_q, ns_q, rd_d;
  logic [10:0] dev_d;
  logic cc_d;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dev_q <= 8'h47;
      tmo_q <= 8'h07;
      ns_q <= 8'h30;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 6'h15) dev_q <= reg_wdata_i & 8'h77;
      if (reg_addr_i == 6'h16) tmo_q <= reg_wdata_i & 8'h1f;
      if (reg_addr_i == 6'h17) ns_q <= reg_wdata_i & 8'h3f;
    end
  end
  assign rd_d = reg_addr_i == 6'h15 ? dev_q : reg_addr_i == 6'h16 ? tmo_q :
                reg_addr_i == 6'h17 ? ns_q : 8'h00;
  assign dev_d = 11'({1'h1, dev_q[2:0]}) << dev_q[6:4];
  assign cc_d = (!ns_q[5] || !pkt_receiving_i) && (!ns_q[4] || rssi_below_thr_i);
  sequence s_sync_held;
    sync_found_i [*3];
  endsequence
  a_rd_value: assert property (1'h1 |=> reg_rdata_o == $past(rd_d))
    else $error("read data mismatch");
  a_fsk_steps: assert property (!msk_mode_i |=> fsk_dev_steps_o == $past(dev_d))
    else $error("deviation steps mismatch");
  a_msk_frac: assert property (msk_mode_i |=> msk_phase_frac_o == $past(dev_q[2:0])
    && fsk_dev_steps_o == 11'h000) else $error("phase fraction mismatch");
  a_clear_channel_sel: assert property (1'h1 |=> cca_o == $past(cc_d))
    else $error("clear channel mismatch");
  a_after_rx: assert property (rx_done_i |=> next_state_o == $past(ns_q[3:2]))
    else $error("state after receive mismatch");
  a_after_tx: assert property (tx_done_i && !rx_done_i |=> next_state_o == $past(ns_q[1:0]))
    else $error("state after transmit mismatch");
  a_valid_pulse: assert property ((rx_done_i || tx_done_i) ##1 !(rx_done_i || tx_done_i)
    |-> next_state_valid_o ##1 !next_state_valid_o) else $error("state valid pulse wrong");
  a_sync_stay: assert property (s_sync_held ##0 !tmo_q[4] |=> !rx_end_o)
    else $error("receive ended despite sync");
  a_timer_abort: assert property (!rx_active_i |-> ##2 !rx_timer_running_o)
    else $error("timer runs outside receive");
endmodule
bind rscb_top rscb_assertions u_rscb_assertions (.*);

// ===== verification/rscb_rc_osc_model.sv
// RC oscillator beside the bank, with a count of its rising edges
`timescale 1ns/1ps
module rscb_rc_osc_model #(
  parameter real HALF_NS = 127.0
) (
  input wire logic en_i,
  input wire logic clr_i,
  output logic rc_clk_o,
  output logic [15:0] ticks_o
);
  initial rc_clk_o = 1'h0;
  // Never stopped while enabled: timeout settings 0 to 6 count these periods
  always #(HALF_NS) rc_clk_o = en_i ? ~rc_clk_o : 1'h0;
  always @(posedge rc_clk_o or posedge clr_i) begin
    if (clr_i) ticks_o <= 16'h0000;
    else ticks_o <= ticks_o + 16'h0001;
  end
endmodule

// ===== verification/radio_state_config_bank_test.sv
// Self-checking bench for the radio state configuration bank
`timescale 1ns/1ps
module radio_state_config_bank_test
  import rscb_pkg::*;
;
  logic core_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wr, msk, act, sync, preamble_quality_threshold, cs, rssi, pkt, rxd, txd, due, rc, cca, endp, run, nsv;
  logic [1:0] res, sel;
  logic [2:0] frac, e;
  logic [5:0] addr, a;
  logic [7:0] wd, rd, d;
  logic [10:0] dev, got;
  logic [15:0] ev, ticks;
  rscb_radio_state_t ns, nq[$];
  logic [10:0] eq[$], tq[$];
  int n_fail = 0, n_compared = 0, cyc = 0, seed = 58, i;
  // Rows: timeout field, wake period, resolution, sync, quality, carrier sense
  logic [28:0] tt[8] = '{{8'h00, 16'h0010, 5'h00}, {8'h01, 16'h0040, 5'h08},
    {8'h06, 16'h0400, 5'h10}, {8'h0a, 16'h0040, 5'h02}, {8'h02, 16'h0040, 5'h04},
    {8'h12, 16'h0040, 5'h1c}, {8'h12, 16'h0040, 5'h05}, {8'h07, 16'h0040, 5'h00}};
  int xt[8] = '{2, 20, 18, 0, 0, 26, 0, 0};
  always #12.5 core_clk_i = ~core_clk_i;
  rscb_top u_rscb_top (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rd), .msk_mode_i(msk),
    .wake_event_period_i(ev), .wake_timer_resolution_i(res), .rc_osc_clk_i(rc),
    .rx_active_i(act), .sync_found_i(sync), .pqt_reached_i(preamble_quality_threshold), .carrier_sense_i(cs),
    .rssi_below_thr_i(rssi), .pkt_receiving_i(pkt), .rx_done_i(rxd), .tx_done_i(txd),
    .fsk_dev_steps_o(dev), .msk_phase_frac_o(frac), .rx_end_o(endp),
    .rx_timer_running_o(run), .cca_o(cca), .next_state_o(ns), .next_state_valid_o(nsv));
  rscb_rc_osc_model u_rscb_rc_osc_model (.en_i(1'h1), .clr_i(!act), .rc_clk_o(rc),
    .ticks_o(ticks));
  assign got = sel == 2'h0 ? {3'h0, rd} : sel == 2'h1 ? dev : sel == 2'h2 ? {8'h00, frac} :
               {10'h000, cca};
  task automatic chk(input string nm, input logic [10:0] x, input logic [10:0] g);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic finish_test();
    n_fail += eq.size() + nq.size() + tq.size();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [5:0] wa, input logic [7:0] wv);
    @(posedge core_clk_i);
    addr <= wa;
    wd <= wv;
    wr <= 1'h1;
    @(posedge core_clk_i);
    wr <= 1'h0;
  endtask
  task automatic look(input logic [1:0] s, input logic [10:0] x);
    @(posedge core_clk_i);
    sel <= s;
    due <= 1'h1;
    eq.push_back(x);
    @(posedge core_clk_i);
    due <= 1'h0;
  endtask
  task automatic rd_reg(input logic [5:0] ra, input logic [7:0] rv);
    @(posedge core_clk_i);
    addr <= ra;
    look(2'h0, {3'h0, rv});
  endtask
  task automatic pulse_done(input logic [1:0] b, input rscb_radio_state_t s);
    @(posedge core_clk_i);
    {rxd, txd} <= b;
    nq.push_back(s);
    @(posedge core_clk_i);
    {rxd, txd} <= 2'h0;
  endtask
  always @(negedge core_clk_i) begin
    if (due) chk("port", eq.pop_front(), got);
    if (nsv === 1'h1) chk("next state", 11'(nq.pop_front()), 11'(ns));
    if (endp === 1'h1) chk("rc ticks", tq.pop_front(), ticks[10:0]);
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    {wr, msk, act, sync, preamble_quality_threshold, cs, rssi, pkt, rxd, txd, due} = 11'h000;
    {res, sel, addr, wd, ev} = 34'h0;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'h0;
    rd_reg(6'h15, 8'h47);
    rd_reg(6'h16, 8'h07);
    rd_reg(6'h17, 8'h30);
    for (i = 0; i < 24; i++) begin
      d = 8'($random(seed));
      a = 6'h15 + 6'(i % 4);
      wr_reg(a, d);
      rd_reg(a, d & (a == 6'h15 ? 8'h77 : a == 6'h16 ? 8'h1f : a == 6'h17 ? 8'h3f : 8'h00));
    end
    for (i = 0; i < 16; i++) begin
      e = 3'(i);
      msk <= i[3];
      wr_reg(6'h15, {1'h1, e, 1'h1, ~e});
      look(2'h1, i[3] ? 11'h000 : 11'({1'h1, ~e}) << e);
      look(2'h2, i[3] ? {8'h00, ~e} : 11'h000);
    end
    for (i = 0; i < 16; i++) begin
      if (i % 4 == 0) wr_reg(6'h17, 8'(i * 4));
      rssi <= i[0];
      pkt <= i[1];
      look(2'h3, 11'((!i[3] || !i[1]) && (!i[2] || i[0])));
    end
    for (i = 0; i < 48; i++) begin
      d = 8'(i / 3);
      if (i % 3 == 0) wr_reg(6'h17, d);
      pulse_done(2'(i % 3 + 1), rscb_radio_state_t'(i % 3 == 0 ? d[1:0] : d[3:2]));
    end
    // Wake-on-radio stays off, so resolutions 2 and 3 are fair game here
    for (i = 0; i < 8; i++) begin
      {d, ev, res, sync, preamble_quality_threshold, cs} <= tt[i];
      @(posedge core_clk_i);
      wr_reg(6'h16, d);
      // Start clear of an oscillator edge so the bench count and the timer agree
      @(posedge rc);
      repeat (6) @(posedge core_clk_i);
      act <= 1'h1;
      if (xt[i] != 0) tq.push_back(11'(xt[i]));
      repeat (300) @(posedge core_clk_i);
      act <= 1'h0;
      repeat (4) @(posedge core_clk_i);
    end
    finish_test();
  end
endmodule
